// *** acr_pkg.sv ***
// Behaviour
// - bit 15: zero reads, one writes; the code only stores it, access direction comes from wb_we_i
// - bits 14:9 address, writable, reads back what was written, resets to 10b
// - bit 8 reserved, always reads zero
// - bit 7 reports self-diagnosis failure
// - bit 6 enables burst mode, default off
// - bit 5 enables channel sequencer, default off
// - bits 4:2 oversampling code, 2^n samples
// - bit 1 appends status to results
// - bit 0 behaves exactly like bit 1
// - register at address 2, resets 0x400
`default_nettype none
package acr_pkg;
  // ==========================================
  // register map
  localparam logic [5:0]  ACR_CFG_INDEX   = 6'h02;
  localparam logic [7:0]  ACR_CFG_OFF     = 8'h08;
  localparam logic [7:0]  ACR_IRQ_STA_OFF = 8'h0C;
  localparam logic [7:0]  ACR_IRQ_MSK_OFF = 8'h10;
  localparam logic [15:0] ACR_CFG_RESET   = 16'h0400;
  localparam logic [15:0] ACR_CFG_WMASK   = 16'h007F;
  localparam int          ACR_DIR_BIT     = 15;
  localparam int          ACR_ADDR_LSB    = 9;
  localparam int          ACR_RSVD_BIT    = 8;
  localparam int          ACR_DIAG_BIT    = 7;
  localparam int          ACR_BURST_BIT   = 6;
  localparam int          ACR_SEQ_BIT     = 5;
  localparam int          ACR_OSR_LSB     = 2;
  localparam int          ACR_STAT_BIT    = 1;
  localparam int          ACR_CHECK_BIT   = 0;
  localparam int          ACR_IRQ_W       = 2;
  typedef struct packed {
    logic       burst_mode_enable;
    logic       sequencer_enable;
    logic [2:0] oversampling_ratio;
    logic       status_append;
    logic [7:0] oversample_count;
  } acr_ctrl_t;
endpackage
`default_nettype wire

// *** acr_config_reg.sv ***
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module acr_config_reg (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_we_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              self_diag_fail_i,
  output acr_pkg::acr_ctrl_t     ctrl_o,
  output logic                   irq_o
);
  // ==========================================
  // synchroniser for the diagnosis input
  logic s1_r, s2_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= self_diag_fail_i;
      s2_r <= s1_r;
    end
  end
  // ==========================================
  // registers and bus
  logic [15:0] cfg_r, cfg_nxt;
  logic [1:0]  sta_r, sta_nxt, msk_r, msk_nxt;
  logic        diag_r, diag_nxt, ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        wr, lo_ok;
  logic [1:0]  ev;
  logic [15:0] rd_cfg;
  always_comb begin
    wr      = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    lo_ok   = wb_sel_i[0] && wb_sel_i[1];
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    diag_nxt = s2_r;
    cfg_nxt = cfg_r;
    msk_nxt = msk_r;
    // event 0: write of config, event 1: diagnosis failure rise
    ev = {s2_r && !diag_r, 1'b0};
    if (wr && wb_adr_i == acr_pkg::ACR_CFG_OFF && lo_ok) begin
      cfg_nxt = (cfg_r & ~acr_pkg::ACR_CFG_WMASK)
              | (wb_dat_i[15:0] & acr_pkg::ACR_CFG_WMASK);
      cfg_nxt[acr_pkg::ACR_DIR_BIT] = wb_dat_i[15];
      cfg_nxt[14:9] = wb_dat_i[14:9];
      ev[0] = 1'b1;
    end
    if (wr && wb_adr_i == acr_pkg::ACR_IRQ_MSK_OFF && wb_sel_i[0]) begin
      msk_nxt = wb_dat_i[1:0];
    end
    sta_nxt = sta_r;
    if (wr && wb_adr_i == acr_pkg::ACR_IRQ_STA_OFF && wb_sel_i[0]) begin
      sta_nxt = sta_r & ~wb_dat_i[1:0];
    end
    sta_nxt = sta_nxt | ev;
    rd_cfg = cfg_r;
    rd_cfg[acr_pkg::ACR_RSVD_BIT] = 1'b0;
    rd_cfg[acr_pkg::ACR_DIAG_BIT] = diag_r;
    case (wb_adr_i)
      acr_pkg::ACR_CFG_OFF:     rd_nxt = {16'h0000, rd_cfg};
      acr_pkg::ACR_IRQ_STA_OFF: rd_nxt = {30'h00000000, sta_r};
      acr_pkg::ACR_IRQ_MSK_OFF: rd_nxt = {30'h00000000, msk_r};
      default:                  rd_nxt = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r  <= acr_pkg::ACR_CFG_RESET;
      sta_r  <= 2'h0;
      msk_r  <= 2'h0;
      diag_r <= 1'b0;
      ack_r  <= 1'b0;
      rd_r   <= 32'h00000000;
    end else begin
      cfg_r  <= cfg_nxt;
      sta_r  <= sta_nxt;
      msk_r  <= msk_nxt;
      diag_r <= diag_nxt;
      ack_r  <= ack_nxt;
      rd_r   <= rd_nxt;
    end
  end
  // ==========================================
  // outputs
  always_comb begin
    wb_ack_o = ack_r;
    wb_dat_o = rd_r;
    irq_o    = |(sta_r & msk_r);
    ctrl_o.burst_mode_enable  = cfg_r[acr_pkg::ACR_BURST_BIT];
    ctrl_o.sequencer_enable   = cfg_r[acr_pkg::ACR_SEQ_BIT];
    ctrl_o.oversampling_ratio = cfg_r[4:2];
    ctrl_o.oversample_count   = (cfg_r[4:2] == 3'h0) ? 8'h01
                              : (8'h01 << cfg_r[4:2]);
    ctrl_o.status_append      = cfg_r[acr_pkg::ACR_STAT_BIT]
                              | cfg_r[acr_pkg::ACR_CHECK_BIT];
  end
  // ==========================================
  // checks
  chk_rsvd_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wb_ack_o && wb_adr_i == acr_pkg::ACR_CFG_OFF |-> !wb_dat_o[8])
    else $error("reserved bit read nonzero");
  chk_diag_track: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s2_r |=> diag_r)
    else $error("diagnosis flag not reported");
  chk_append_or: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_o.status_append == (cfg_r[1] || cfg_r[0]))
    else $error("append not or of bits 1 and 0");
  chk_ro_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> cfg_r[8:7] == 2'b00)
    else $error("read-only bits written");
  chk_osr_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_r[4:2] == 3'h7 |-> ctrl_o.oversample_count == 8'h80)
    else $error("oversampling count wrong");
  chk_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(s2_r) ##1 msk_r[1] |-> ##1 irq_o)
    else $error("diagnosis interrupt missing");
  chk_bus_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  chk_write_take: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr && wb_adr_i == acr_pkg::ACR_CFG_OFF && lo_ok
      |=> cfg_r[6:0] == $past(wb_dat_i[6:0]) && cfg_r[14:9] == $past(wb_dat_i[14:9]))
    else $error("config write not taken");
endmodule
`default_nettype wire

// *** acr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side bus master
module acr_host_model (
  input  wire logic        clk_i,
  output logic      [7:0]  adr_o,
  output logic      [31:0] dat_o,
  output logic             we_o,
  output logic             cyc_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  initial begin
    {adr_o, dat_o, we_o, cyc_o} = '0;
  end
  // argument w picks direction, byte address a picks the register
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    adr_o <= a;
    dat_o <= d;
    we_o  <= w;
    cyc_o <= 1'b1;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// *** tb_adc_config_register.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module tb_adc_config_register;
  logic               clk_i = 1'b0, rst_n_i = 1'b0, dg = 1'b0, ack, cyc, we, irq;
  logic [7:0]         adr;
  logic [31:0]        wd, rdat, q;
  acr_pkg::acr_ctrl_t ctrl;
  int                 error_cnt = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  acr_host_model host (.clk_i(clk_i), .adr_o(adr), .dat_o(wd), .we_o(we), .cyc_o(cyc),
    .dat_i(rdat), .ack_i(ack));
  acr_config_reg uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
    .wb_ack_o(ack), .self_diag_fail_i(dg), .ctrl_o(ctrl), .irq_o(irq));
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.acc(1'b0, a, 32'h0, q);
    chk("read", q, e);
  endtask
  task automatic ck_irq(input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic t_fields;
    logic [2:0] c;
    rd(8'h08, 32'h0000_0400);
    host.acc(1'b1, 8'h08, 32'hFFFF_FFFF, q);
    rd(8'h08, 32'h0000_FE7F);
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      host.acc(1'b1, 8'h08, {25'h8, c[0], c[1], c, c[1:0]}, q);
      chk("ctrl", {18'h0, ctrl}, {18'h0, c[0], c[1], c, |c[1:0], 8'h01 << c});
    end
    host.acc(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    rd(8'h40, 32'h0);
  endtask
  task automatic t_irq_diag;
    rd(8'h0C, 32'h1);
    ck_irq(1'b0);
    host.acc(1'b1, 8'h10, 32'h1, q);
    ck_irq(1'b1);
    host.acc(1'b1, 8'h0C, 32'h1, q);
    ck_irq(1'b0);
    @(posedge clk_i);
    dg <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(8'h08, 32'h0000_04FF);
    rd(8'h0C, 32'h2);
    host.acc(1'b1, 8'h10, 32'h2, q);
    ck_irq(1'b1);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    dg <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h08, 32'h0000_0400);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_fields;
    t_irq_diag;
    report_and_stop;
  end
  initial begin
    #50000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
